// ==== rtl/aer_pkg.sv ====
// Shared constants for the error capability and channel capability bank.
// Assumes a 32-bit AXI4-Lite register bus on the core clock.
package aer_pkg;
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] OFS_CAPS_CTRL   = 12'h118;
    localparam logic [11:0] OFS_HDR_LOG0    = 12'h11C;
    localparam logic [11:0] OFS_HDR_LOG3    = 12'h128;
    localparam logic [11:0] OFS_CHAN_HDR    = 12'h140;
    localparam logic [11:0] OFS_CHAN_CAP1   = 12'h144;
    localparam logic [11:0] OFS_CHAN_CAP2   = 12'h148;
    localparam logic [11:0] OFS_ERR_EVENT   = 12'h130;

    localparam int          FEP_LSB         = 0;
    localparam int          GEN_CAP_BIT     = 5;
    localparam int          GEN_EN_BIT      = 6;
    localparam int          CHK_CAP_BIT     = 7;
    localparam int          CHK_EN_BIT      = 8;
    localparam logic [4:0]  FEP_RST         = 5'h00;
    localparam logic        GEN_CAP_RST     = 1'b1;
    localparam logic        CHK_CAP_RST     = 1'b1;

    localparam logic [15:0] CHAN_CAP_ID     = 16'h0002;
    localparam logic [3:0]  CHAN_CAP_VER    = 4'h1;
    localparam logic [11:0] CHAN_NEXT_PTR   = 12'h20C;

    localparam logic [1:0]  EXT_CNT_HI_RST  = 2'h0;
    localparam logic [2:0]  LOW_GRP_RST     = 3'h0;
    localparam logic [1:0]  REF_CLK_100NS   = 2'h0;
    localparam logic [1:0]  ARB_ENTRY_4BIT  = 2'h2;
    localparam logic [7:0]  ARB_CAP_ON      = 8'h03;
    localparam logic [7:0]  ARB_CAP_OFF     = 8'h00;
    localparam logic [7:0]  ARB_TBL_ON      = 8'h03;
    localparam logic [7:0]  ARB_TBL_OFF     = 8'h00;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : aer_pkg

// ==== rtl/aer_cfg_if.sv ====
// Write strobe bundle from the bus slave to the register store.
// Assumes one clock domain.
`timescale 1ns/1ns
`default_nettype none
interface aer_cfg_if;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
    modport src (output wr, addr, data, strb);
    modport dst (input wr, addr, data, strb);
endinterface : aer_cfg_if
`default_nettype wire

// ==== rtl/aer_hdr_log.sv ====
// Header log capture: first error pointer and four header doublewords.
// Assumes error events arrive as one-cycle pulses with full header.
`timescale 1ns/1ns
`default_nettype none
module aer_hdr_log
    import aer_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         err_i,
    input  wire logic         err_masked_i,
    input  wire logic [4:0]   err_bit_i,
    input  wire logic [127:0] err_hdr_i,
    input  wire logic         rearm_i,
    output logic              armed_o,
    output logic [4:0]        fep_o,
    output logic [127:0]      log_o
);
    // Only the first unmasked error is kept until software rearms
    wire take = err_i && !err_masked_i && armed_o;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fep_o <= FEP_RST;
            log_o <= '0;
        end else if (take) begin
            fep_o <= err_bit_i;
            log_o <= err_hdr_i;
        end
    end

    // Capture wins over a rearm in the same cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed_o <= 1'b1;
        end else if (take) begin
            armed_o <= 1'b0;
        end else if (rearm_i) begin
            armed_o <= 1'b1;
        end
    end
endmodule : aer_hdr_log
`default_nettype wire

// ==== rtl/aer_regs.sv ====
// Sticky enables and channel count fields written by software or autoload.
// Assumes sticky reset is separate from the ordinary bus reset.
`timescale 1ns/1ns
`default_nettype none
module aer_regs
    import aer_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    input  wire logic   strap_i,
    input  wire logic   load_i,
    input  wire logic [2:0] load_ext_i,
    input  wire logic [2:0] load_low_i,
    aer_cfg_if.dst      cfg,
    output logic        gen_en_o,
    output logic        chk_en_o,
    output logic [2:0]  ext_cnt_o,
    output logic [2:0]  low_cnt_o
);
    logic strap_seen;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gen_en_o <= 1'b0;
            chk_en_o <= 1'b0;
        end else if (cfg.wr && cfg.addr == OFS_CAPS_CTRL) begin
            if (cfg.strb[0]) gen_en_o <= cfg.data[GEN_EN_BIT];
            if (cfg.strb[1]) chk_en_o <= cfg.data[CHK_EN_BIT];
        end
    end

    // Strap is caught on the first clock after reset release
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_seen <= 1'b0;
            ext_cnt_o  <= '0;
            low_cnt_o  <= LOW_GRP_RST;
        end else if (!strap_seen) begin
            strap_seen <= 1'b1;
            ext_cnt_o  <= {EXT_CNT_HI_RST, strap_i};
        end else if (load_i) begin
            ext_cnt_o  <= load_ext_i;
            low_cnt_o  <= load_low_i;
        end
    end
endmodule : aer_regs
`default_nettype wire

// ==== rtl/aer_vc_cap_regs.sv ====
// Function
// - First error pointer, sticky read-only, records first uncorrectable bit.
// - Bit 5 reads one: end-to-end CRC generation capable.
// - Bit 6 sticky writable CRC generation enable, resets zero.
// - Bit 7 reads one: end-to-end CRC check capable.
// - Bit 8 sticky writable CRC check enable, resets zero.
// - Header log holds four sticky read-only doublewords.
// - Header bytes big-endian, first byte in most significant byte.
// - Channel capability header id reads 0002h in bits 15:0.
// - Channel capability header version reads 1h in bits 19:16.
// - Next capability pointer reads 20Ch in bits 31:20.
// - Channel count: upper bits zero, bit 0 from strap; autoload overrides.
// - Low-priority group count in bits 6:4, resets zero, autoload overrides.
// - Reference clock field 9:8 reads 00b, 100 ns.
// - Bits 11:10 read 10b, four-bit arbitration table entries.
// - Arbitration capability 03h when count bit 0 set, else 00h.
// - Arbitration table offset 03h when count bit 0 set, else 00h.
// - Masked error neither logs header nor reports upstream.
//
// Top: AXI4-Lite slave over the error and channel capability words.
// Assumes the sticky reset comes from the power-on domain.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module aer_vc_cap_regs
    import aer_pkg::*;
(
    input  wire logic         SYS_CLK_I,
    input  wire logic         RST_N_I,
    input  wire logic         S_AXI_AWVALID_I,
    output logic              S_AXI_AWREADY_O,
    input  wire logic [11:0]  S_AXI_AWADDR_I,
    input  wire logic         S_AXI_WVALID_I,
    output logic              S_AXI_WREADY_O,
    input  wire logic [31:0]  S_AXI_WDATA_I,
    input  wire logic [3:0]   S_AXI_WSTRB_I,
    output logic              S_AXI_BVALID_O,
    input  wire logic         S_AXI_BREADY_I,
    output logic [1:0]        S_AXI_BRESP_O,
    input  wire logic         S_AXI_ARVALID_I,
    output logic              S_AXI_ARREADY_O,
    input  wire logic [11:0]  S_AXI_ARADDR_I,
    output logic              S_AXI_RVALID_O,
    input  wire logic         S_AXI_RREADY_I,
    output logic [31:0]       S_AXI_RDATA_O,
    output logic [1:0]        S_AXI_RRESP_O,
    input  wire logic         SECOND_CHANNEL_STRAP_I,
    input  wire logic         AUTOLOAD_I,
    input  wire logic [2:0]   AUTOLOAD_EXT_CNT_I,
    input  wire logic [2:0]   AUTOLOAD_LOW_CNT_I,
    input  wire logic         ERR_EVENT_I,
    input  wire logic         ERR_MASKED_I,
    input  wire logic [4:0]   ERR_BIT_I,
    input  wire logic [127:0] ERR_HDR_I,
    output logic              ERR_MSG_O,
    output logic              CRC_GEN_EN_O,
    output logic              CRC_CHK_EN_O
);
    aer_cfg_if cfg ();

    logic [11:0]  aw_addr;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         aw_held;
    logic         w_held;
    logic         gen_en;
    logic         chk_en;
    logic [2:0]   ext_cnt;
    logic [2:0]   low_cnt;
    logic         armed;
    logic [4:0]   fep;
    logic [127:0] hdr_log;
    logic [31:0]  next_rdata;
    logic         next_rerr;
    logic [31:0]  log_word [4];

    function automatic logic known(input logic [11:0] a);
        known = (a[1:0] == 2'h0) &&
                (a == OFS_CAPS_CTRL || a == OFS_CHAN_HDR ||
                 a == OFS_CHAN_CAP1 || a == OFS_CHAN_CAP2 ||
                 a == OFS_ERR_EVENT ||
                 (a >= OFS_HDR_LOG0 && a <= OFS_HDR_LOG3));
    endfunction : known

    // Both arbitration fields vanish when bit 0 of the channel count is clear
    function automatic logic [7:0] arb_field(input logic       on,
                                             input logic [7:0] yes,
                                             input logic [7:0] no);
        arb_field = on ? yes : no;
    endfunction : arb_field

    wire wr_go = aw_held && w_held && !S_AXI_BVALID_O;
    wire aw_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
    wire w_take  = S_AXI_WVALID_I && S_AXI_WREADY_O;
    wire ar_take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    // Writing one to bit 0 of the event word rearms the header log
    wire rearm   = cfg.wr && aw_addr == OFS_ERR_EVENT &&
                   w_strb[0] && w_data[0];

    assign cfg.wr   = wr_go && known(aw_addr);
    assign cfg.addr = aw_addr;
    assign cfg.data = w_data;
    assign cfg.strb = w_strb;

    // Address and data are taken in either order, one write at a time
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aw_held <= 1'b0;
        end else if (aw_take) begin
            aw_held <= 1'b1;
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aw_addr <= '0;
        end else if (aw_take) begin
            aw_addr <= S_AXI_AWADDR_I;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            w_held <= 1'b0;
        end else if (w_take) begin
            w_held <= 1'b1;
        end else if (wr_go) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            w_data <= '0;
            w_strb <= '0;
        end else if (w_take) begin
            w_data <= S_AXI_WDATA_I;
            w_strb <= S_AXI_WSTRB_I;
        end
    end

    // Ready pulses every other idle cycle, so each pulse takes one item
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            S_AXI_AWREADY_O <= 1'b0;
        end else begin
            S_AXI_AWREADY_O <= !aw_held && !S_AXI_AWREADY_O &&
                               !S_AXI_BVALID_O;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            S_AXI_WREADY_O <= 1'b0;
        end else begin
            S_AXI_WREADY_O <= !w_held && !S_AXI_WREADY_O &&
                              !S_AXI_BVALID_O;
        end
    end

    // Unmapped writes still complete, with an error answer
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            S_AXI_BVALID_O <= 1'b0;
        end else if (wr_go) begin
            S_AXI_BVALID_O <= 1'b1;
        end else if (S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
        end
    end

    // Code stands with the answer and only moves on the next write
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            S_AXI_BRESP_O <= RESP_OKAY;
        end else if (wr_go) begin
            S_AXI_BRESP_O <= known(aw_addr) ? RESP_OKAY
                                            : RESP_SLVERR;
        end
    end

    aer_regs u_regs (
        .clk_i      (SYS_CLK_I),
        .rst_n_i    (RST_N_I),
        .strap_i    (SECOND_CHANNEL_STRAP_I),
        .load_i     (AUTOLOAD_I),
        .load_ext_i (AUTOLOAD_EXT_CNT_I),
        .load_low_i (AUTOLOAD_LOW_CNT_I),
        .cfg        (cfg),
        .gen_en_o   (gen_en),
        .chk_en_o   (chk_en),
        .ext_cnt_o  (ext_cnt),
        .low_cnt_o  (low_cnt)
    );

    aer_hdr_log u_log (
        .clk_i        (SYS_CLK_I),
        .rst_n_i      (RST_N_I),
        .err_i        (ERR_EVENT_I),
        .err_masked_i (ERR_MASKED_I),
        .err_bit_i    (ERR_BIT_I),
        .err_hdr_i    (ERR_HDR_I),
        .rearm_i      (rearm),
        .armed_o      (armed),
        .fep_o        (fep),
        .log_o        (hdr_log)
    );

    // Message follows an unmasked event by one clock
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ERR_MSG_O <= 1'b0;
        end else begin
            ERR_MSG_O <= ERR_EVENT_I && !ERR_MASKED_I;
        end
    end

    // Enables reach the pins one clock after the register
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            CRC_GEN_EN_O <= 1'b0;
            CRC_CHK_EN_O <= 1'b0;
        end else begin
            CRC_GEN_EN_O <= gen_en;
            CRC_CHK_EN_O <= chk_en;
        end
    end

    // Header dwords in bus order; first header byte sits in the top byte
    generate
        for (genvar i = 0; i < 4; i++) begin : g_log_word
            assign log_word[i] = hdr_log[127 - 32 * i -: 32];
        end
    endgenerate

    // Read mux; every bit not named stays zero
    always_comb begin
        next_rdata = '0;
        next_rerr  = 1'b0;
        case (S_AXI_ARADDR_I)
            OFS_CAPS_CTRL: begin
                next_rdata[FEP_LSB +: 5]  = fep;
                next_rdata[GEN_CAP_BIT]   = GEN_CAP_RST;
                next_rdata[GEN_EN_BIT]    = gen_en;
                next_rdata[CHK_CAP_BIT]   = CHK_CAP_RST;
                next_rdata[CHK_EN_BIT]    = chk_en;
            end
            OFS_HDR_LOG0:
                next_rdata = log_word[0];
            OFS_HDR_LOG0 + 12'h004:
                next_rdata = log_word[1];
            OFS_HDR_LOG0 + 12'h008:
                next_rdata = log_word[2];
            OFS_HDR_LOG3:
                next_rdata = log_word[3];
            OFS_ERR_EVENT:
                next_rdata[0] = armed;
            OFS_CHAN_HDR:
                next_rdata = {CHAN_NEXT_PTR, CHAN_CAP_VER,
                              CHAN_CAP_ID};
            OFS_CHAN_CAP1: begin
                next_rdata[2:0]   = ext_cnt;
                next_rdata[6:4]   = low_cnt;
                next_rdata[9:8]   = REF_CLK_100NS;
                next_rdata[11:10] = ARB_ENTRY_4BIT;
            end
            OFS_CHAN_CAP2: begin
                next_rdata[7:0]   = arb_field(ext_cnt[0], ARB_CAP_ON,
                                              ARB_CAP_OFF);
                next_rdata[31:24] = arb_field(ext_cnt[0], ARB_TBL_ON,
                                              ARB_TBL_OFF);
            end
            default:
                next_rerr = 1'b1;
        endcase
    end

    // Single-entry read path; address offered only while no answer waits
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            S_AXI_ARREADY_O <= 1'b0;
        end else if (ar_take || S_AXI_RVALID_O) begin
            S_AXI_ARREADY_O <= 1'b0;
        end else begin
            S_AXI_ARREADY_O <= S_AXI_ARVALID_I && !S_AXI_ARREADY_O;
        end
    end

    // Answer shows the cycle after the address is taken
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            S_AXI_RVALID_O <= 1'b0;
        end else if (ar_take) begin
            S_AXI_RVALID_O <= 1'b1;
        end else if (S_AXI_RREADY_I) begin
            S_AXI_RVALID_O <= 1'b0;
        end
    end

    // Data and code hold until the next address is taken
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            S_AXI_RDATA_O <= '0;
            S_AXI_RRESP_O <= RESP_OKAY;
        end else if (ar_take) begin
            S_AXI_RDATA_O <= next_rdata;
            S_AXI_RRESP_O <= next_rerr ? RESP_SLVERR : RESP_OKAY;
        end
    end
endmodule : aer_vc_cap_regs
`default_nettype wire

// ==== verif/aer_vc_cap_regs_chk.sv ====
// Checker: read-back values, message timing and enable mirrors.
// Assumes it is bound onto the top register module.
`timescale 1ns/1ns
`default_nettype none
module aer_vc_cap_regs_chk
    import aer_pkg::*;
(
    input wire logic        SYS_CLK_I,
    input wire logic        RST_N_I,
    input wire logic        S_AXI_ARVALID_I,
    input wire logic        S_AXI_ARREADY_O,
    input wire logic [11:0] S_AXI_ARADDR_I,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [1:0]  S_AXI_RRESP_O,
    input wire logic        S_AXI_BVALID_O,
    input wire logic        ERR_EVENT_I,
    input wire logic        ERR_MASKED_I,
    input wire logic        ERR_MSG_O,
    input wire logic        CRC_GEN_EN_O,
    input wire logic        CRC_CHK_EN_O
);
    default clocking @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    sequence rd_take(logic [11:0] a);
        S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == a;
    endsequence
    sequence masked_evt;
        ERR_EVENT_I && ERR_MASKED_I;
    endsequence

    chan_hdr_a: assert property (
        rd_take(OFS_CHAN_HDR) |=>
        S_AXI_RDATA_O == {CHAN_NEXT_PTR, CHAN_CAP_VER, CHAN_CAP_ID})
        else $error("capability header word wrong");
    caps_word_a: assert property (
        rd_take(OFS_CAPS_CTRL) |=> S_AXI_RDATA_O[GEN_CAP_BIT] &&
        S_AXI_RDATA_O[CHK_CAP_BIT] && S_AXI_RDATA_O[31:9] == 23'h0)
        else $error("control word fixed bits wrong");
    chan_one_a: assert property (
        rd_take(OFS_CHAN_CAP1) |=> S_AXI_RDATA_O[31:8] ==
        {20'h0, ARB_ENTRY_4BIT, REF_CLK_100NS} && !S_AXI_RDATA_O[7]
        && !S_AXI_RDATA_O[3])
        else $error("channel capability one wrong");
    chan_two_a: assert property (
        rd_take(OFS_CHAN_CAP2) |=> S_AXI_RDATA_O[23:8] == 16'h0 &&
        S_AXI_RDATA_O[7:0] == S_AXI_RDATA_O[31:24] &&
        (S_AXI_RDATA_O[7:0] == ARB_CAP_ON || S_AXI_RDATA_O[7:0] == 8'h00))
        else $error("channel capability two wrong");
    unmapped_rd_a: assert property (
        rd_take(12'h200) |=> S_AXI_RRESP_O == RESP_SLVERR &&
        S_AXI_RDATA_O == 32'h0)
        else $error("unmapped read not refused");
    masked_quiet_a: assert property (
        masked_evt |=> !ERR_MSG_O)
        else $error("masked event reported");
    msg_cause_a: assert property (
        ERR_MSG_O |-> $past(ERR_EVENT_I) && !$past(ERR_MASKED_I))
        else $error("message without unmasked event");
    // Enables may only move right after a write answer
    crc_mirror_a: assert property (
        $changed(CRC_GEN_EN_O) || $changed(CRC_CHK_EN_O) |->
        $past(S_AXI_BVALID_O))
        else $error("enable changed without a write");
endmodule : aer_vc_cap_regs_chk

bind aer_vc_cap_regs aer_vc_cap_regs_chk aer_vc_cap_regs_chk_inst (
    .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I),
    .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
    .S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_RDATA_O(S_AXI_RDATA_O),
    .S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
    .ERR_EVENT_I(ERR_EVENT_I), .ERR_MASKED_I(ERR_MASKED_I),
    .ERR_MSG_O(ERR_MSG_O), .CRC_GEN_EN_O(CRC_GEN_EN_O),
    .CRC_CHK_EN_O(CRC_CHK_EN_O));
`default_nettype wire

// ==== verif/test_aer_vc_cap_regs.sv ====
// Bench: register reads and writes over AXI4-Lite, error capture.
// Assumes the register module and its bound checker are compiled.
`timescale 1ns/1ns
`default_nettype none
module test_aer_vc_cap_regs
    import aer_pkg::*;
();
    logic clk = 1'b0, rst_n = 1'b0, strap = 1'b1, load = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, evt = 1'b0, masked = 1'b0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic [2:0] lext = 3'h0, llow = 3'h0;
    logic [4:0] ebit = 5'h0;
    logic [127:0] hdr = 128'h0, h, keep;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, msg, gen, chk;
    logic [15:0] lfsr = 16'h714E; // 29006
    logic [33:0] exp_q[$];
    int num_errors = 0, checks_done = 0, cycles = 0, k;

    aer_vc_cap_regs aer_vc_cap_regs_inst (
        .SYS_CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_AWADDR_I(awaddr),
        .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
        .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_ARADDR_I(araddr),
        .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
        .SECOND_CHANNEL_STRAP_I(strap), .AUTOLOAD_I(load),
        .AUTOLOAD_EXT_CNT_I(lext), .AUTOLOAD_LOW_CNT_I(llow),
        .ERR_EVENT_I(evt), .ERR_MASKED_I(masked), .ERR_BIT_I(ebit),
        .ERR_HDR_I(hdr), .ERR_MSG_O(msg), .CRC_GEN_EN_O(gen),
        .CRC_CHK_EN_O(chk));

    always #5 clk = ~clk;

    task automatic end_sim;
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic compare(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask : compare

    task automatic compare_pin(input logic got, input logic exp);
        compare({33'h0, got}, {33'h0, exp});
    endtask : compare_pin

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    function automatic logic [31:0] caps(input logic [4:0] f, input logic g,
                                         input logic c);
        return {23'h0, c, CHK_CAP_RST, g, GEN_CAP_RST, f};
    endfunction : caps

    // Takes answers in order; one transfer is open at a time
    always @(posedge clk) begin
        cycles++;
        if (rvalid && rready) begin
            compare({rresp, rdata}, exp_q.pop_front());
        end else if (bvalid && bready) begin
            compare({bresp, 32'h0}, exp_q.pop_front());
        end
        if (cycles == 6000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic rd(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        exp_q.push_back({r, d});
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        exp_q.push_back({r, 32'h0});
        @(posedge clk);
        {awvalid, wvalid, bready} <= 3'h7;
        {awaddr, wdata, wstrb} <= {a, d, s};
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awready && !aw_ok) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w_ok) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
    endtask : wr

    task automatic chan(input logic [2:0] lo, input logic [2:0] ex);
        rd(OFS_CHAN_CAP1, {20'h0, ARB_ENTRY_4BIT, REF_CLK_100NS, 1'b0, lo,
           1'b0, ex}, RESP_OKAY);
        rd(OFS_CHAN_CAP2, ex[0] ? {ARB_TBL_ON, 16'h0, ARB_CAP_ON} :
           {ARB_TBL_OFF, 16'h0, ARB_CAP_OFF}, RESP_OKAY);
    endtask : chan

    // Random header; message due one cycle after an unmasked event
    task automatic err(input logic m, input logic [4:0] b);
        for (k = 0; k < 8; k++) begin
            lfsr = lfsr_next(lfsr);
            h = {h[111:0], lfsr};
        end
        @(posedge clk);
        {evt, masked, ebit, hdr} <= {1'b1, m, b, h};
        @(posedge clk);
        evt <= 1'b0;
        @(posedge clk);
        compare_pin(msg, !m);
    endtask : err

    task automatic hlog(input logic [127:0] x);
        for (k = 0; k < 4; k++) begin
            rd(OFS_HDR_LOG0 + 12'(4 * k), x[127 - 32 * k -: 32],
               RESP_OKAY);
        end
    endtask : hlog

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CAPS_CTRL, caps(FEP_RST, 1'b0, 1'b0), RESP_OKAY);
        hlog(128'h0);
        rd(OFS_CHAN_HDR, {CHAN_NEXT_PTR, CHAN_CAP_VER, CHAN_CAP_ID},
           RESP_OKAY);
        chan(LOW_GRP_RST, {EXT_CNT_HI_RST, 1'b1});
        wr(OFS_CAPS_CTRL, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        rd(OFS_CAPS_CTRL, caps(5'h0, 1'b1, 1'b1), RESP_OKAY);
        compare_pin(gen, 1'b1);
        compare_pin(chk, 1'b1);
        wr(OFS_CAPS_CTRL, 32'h0, 4'h2, RESP_OKAY);
        rd(OFS_CAPS_CTRL, caps(5'h0, 1'b1, 1'b0), RESP_OKAY);
        wr(OFS_CHAN_HDR, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        wr(OFS_CHAN_CAP1, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        chan(3'h0, 3'h1);
        wr(12'h204, 32'h1, 4'hF, RESP_SLVERR);
        wr(12'h119, 32'h1, 4'hF, RESP_SLVERR);
        rd(12'h200, 32'h0, RESP_SLVERR);
        err(1'b1, 5'h0C);
        hlog(128'h0);
        err(1'b0, 5'h13);
        // Later events drive a new header; the log must keep this one
        keep = h;
        rd(OFS_CAPS_CTRL, caps(5'h13, 1'b1, 1'b0), RESP_OKAY);
        hlog(keep);
        err(1'b0, 5'h04);
        rd(OFS_CAPS_CTRL, caps(5'h13, 1'b1, 1'b0), RESP_OKAY);
        hlog(keep);
        rd(OFS_ERR_EVENT, 32'h0, RESP_OKAY);
        wr(OFS_ERR_EVENT, 32'h1, 4'h1, RESP_OKAY);
        rd(OFS_ERR_EVENT, 32'h1, RESP_OKAY);
        @(posedge clk);
        {load, lext, llow} <= {1'b1, 3'h5, 3'h6};
        @(posedge clk);
        load <= 1'b0;
        chan(3'h6, 3'h5);
        @(posedge clk);
        {load, lext, llow} <= {1'b1, 3'h2, 3'h0};
        @(posedge clk);
        load <= 1'b0;
        chan(3'h0, 3'h2);
        // Second reset with the strap low
        @(posedge clk);
        {rst_n, strap} <= 2'b00;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        chan(LOW_GRP_RST, 3'h0);
        rd(OFS_CAPS_CTRL, caps(FEP_RST, 1'b0, 1'b0), RESP_OKAY);
        hlog(128'h0);
        compare_pin(gen, 1'b0);
        compare_pin(chk, 1'b0);
        end_sim();
    end
endmodule : test_aer_vc_cap_regs
`default_nettype wire
